// >>> common/cim_pkg.sv
package cim_pkg;

  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] CIM_OFF_CHAN_OUT = 8'h00;
  localparam logic [7:0] CIM_OFF_CHAN_IN = 8'h04;
  localparam logic [7:0] CIM_OFF_CTRL_STATE = 8'h08;
  localparam logic [7:0] CIM_OFF_XFER_WORD = 8'h0C;
  localparam logic [7:0] CIM_OFF_EXTRA_ONE = 8'h10;
  localparam logic [7:0] CIM_OFF_CONTROL = 8'h14;

  localparam logic [2:0] CIM_IDX_CHAN_OUT = 3'h0;
  localparam logic [2:0] CIM_IDX_CHAN_IN = 3'h1;
  localparam logic [2:0] CIM_IDX_CTRL_STATE = 3'h2;
  localparam logic [2:0] CIM_IDX_XFER_WORD = 3'h3;
  localparam logic [2:0] CIM_IDX_EXTRA_ONE = 3'h4;
  localparam logic [2:0] CIM_IDX_CONTROL = 3'h5;
  localparam logic [2:0] CIM_IDX_NONE = 3'h7;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CIM_OUT_PARITY_BIT = 8;
  localparam int CIM_IN_OPERATIONAL = 15;
  localparam int CIM_IN_SELECT = 14;
  localparam int CIM_IN_REQUEST = 13;
  localparam int CIM_IN_ADDRESS = 12;
  localparam int CIM_IN_STATUS = 11;
  localparam int CIM_IN_SERVICE = 10;
  localparam int CIM_IN_CLOCK_OUT = 9;
  localparam int CIM_IN_PARITY = 8;
  localparam int CIM_CS_LOCKOUT = 15;
  localparam int CIM_CS_PHASE_LO = 12;
  localparam int CIM_CS_TIME_STATE = 11;
  localparam int CIM_CS_FAST_BUSY = 10;
  localparam int CIM_CS_SYNC = 9;
  localparam int CIM_CS_UNIT_DATA = 8;
  localparam int CIM_CS_STOP_OR = 7;
  localparam int CIM_CS_BYPASS = 6;
  localparam int CIM_CS_XFER_REQ = 5;
  localparam int CIM_CS_XFER_DIR = 4;
  localparam int CIM_CS_BYTE_ALT = 3;
  localparam int CIM_CS_ONLINE = 2;
  localparam int CIM_CS_UNIT_MATCH = 1;
  localparam int CIM_CS_DEV_MATCH = 0;
  localparam int CIM_CTL_ONLINE_REQ = 9;
  localparam int CIM_CTL_CABLED = 0;

  // Software may write these bits of the inbound register
  localparam logic [15:0] CIM_IN_WRITE_MASK = 16'hFCFF;
  // Bits of the inbound register kept through bus initialize
  localparam logic [15:0] CIM_IN_KEEP_MASK = 16'h4000;
  // Control-unit part of the unit address
  localparam logic [7:0] CIM_UNIT_ADDR_MASK = 8'hF0;
  localparam logic [2:0] CIM_PHASE_DATA_A = 3'h5;
  localparam logic [2:0] CIM_PHASE_DATA_B = 3'h6;

  localparam logic [15:0] CIM_RST_WORD = 16'h0000;
  localparam logic [7:0] CIM_RST_BYTE = 8'h00;
  localparam logic [31:0] CIM_RST_RDATA = 32'h00000000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    CIM_BUS_IDLE = 4'b0001,
    CIM_BUS_WRITE = 4'b0010,
    CIM_BUS_RD_WAIT = 4'b0100,
    CIM_BUS_RD_DONE = 4'b1000
  } cim_bus_t;

  typedef struct packed {
    cim_bus_t bus;
    logic [2:0] ap_idx;
    logic [31:0] rdata;
    logic [15:0] out_buf;
    logic [15:0] in_reg;
    logic [15:0] cs_reg;
    logic [15:0] xfer_word;
    logic [7:0] tumble_idx;
    logic online_request;
    logic cabled_test;
  } cim_state_t;

endpackage : cim_pkg

// >>> verilog/cim_regs.sv
// Behaviour
// - In cabled test, written parity bit drives simulated clock-out and parity lines.
// - Parity is odd over nine bits; even ones in data gives parity one.
// - Software can force good or bad outbound parity via the parity bit.
// - Inbound flops drive bus-in only while operational-in or fast busy.
// - Inbound register writable for maintenance except clock-out and parity bits.
// - Inbound read gives internal register off-line, test-in plug on-line.
// - Inbound parity bit is combinational parity of the inbound data byte.
// - Inbound control byte bit layout 15 down to 08; select-in survives clear.
// - Clock-out test bit always follows the cable line.
// - Control-state read-only; initialize clears it except the on-line bit 02.
// - Lockout set makes the programmable setup registers read-only.
// - Bits 14..12 carry the current major phase code.
// - Bit 11 time state: zero second state, one first state.
// - Bit 07 is combinational OR of transfer-stop conditions in phase 5/6.
// - Bypass bit 06 marks first byte, skips and fast busy reply.
// - Bit 05 high while a memory transfer is requested, low when done.
// - Bit 04 zero for reads from memory, one for writes into memory.
// - Bit 03 byte alternator: held-status use, data-word half in phases 5/6.
// - Bit 02 is second stage of on-line request, not cleared by initialize.
// - Bit 01 live unit-address match; bit 00 device match only with bit 01.
// - Transfer data register holds each memory-transfer word for diagnostics.
// - Tumble index in bits 15..08, shifted left one into the address register.
// - Software outbound writes go to a buffered register, not the live view.
module cim_regs
  import cim_pkg::*;
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic bus_init, // Bus initialize
  input wire logic [15:0] bus_out_lines, // Live channel bus-out and tags
  input wire logic [15:0] test_in_plug, // Levels at test-in plug
  input wire logic clock_out_line, // Clock-out line from cable
  input wire logic online_switch_en, // On-line switch enabled
  input wire logic channel_active, // Channel activity in progress
  input wire logic core_in_load, // Core loads inbound register
  input wire logic [15:0] core_in_value, // Core inbound value
  input wire logic lockout_flag, // Core lockout
  input wire logic [2:0] core_phase, // Core major phase
  input wire logic time_state_flag, // One in first time state
  input wire logic fast_busy_diag, // Fast busy in progress
  input wire logic core_sync, // Phase synchroniser
  input wire logic unit_data_ctrl, // Unit data control
  input wire logic bypass_flag, // Core bypass
  input wire logic transfer_request_flag, // Memory transfer requested
  input wire logic transfer_direction, // One writes into memory
  input wire logic byte_alternator, // Byte alternator
  input wire logic [3:0] stop_conditions, // Transfer stop causes
  input wire logic [7:0] unit_address, // Assigned unit address
  input wire logic xfer_word_valid, // Memory transfer word strobe
  input wire logic [15:0] xfer_word_in, // Memory transfer word
  input wire logic tumble_advance, // Step tumble index
  input wire logic [6:0] misc_signals, // Miscellaneous signals
  output logic [15:0] test_out_lines, // Buffered bus-out to drivers
  output logic sim_clock_out, // Simulated clock-out
  output logic parity_out_line, // Outbound parity line
  output logic out_parity_good, // Live bus-out parity check
  output logic [15:0] bus_in_o, // Bus-in lines
  output logic bus_in_oe, // Bus-in drive enable
  output logic online_actual, // Connected to channel
  output logic online_request, // Requested on-line
  output logic cabled_test, // Cabled test mode
  output logic regs_locked, // Setup registers read-only
  output logic [8:0] tumble_addr_low // Tumble index shifted
);
  import cim_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~(^d);
  endfunction : odd_par

  function automatic logic [2:0] decode(input logic [31:0] a);
    decode = CIM_IDX_NONE;
    if (a[31:8] == 24'h000000) begin
      unique case (a[7:0])
        CIM_OFF_CHAN_OUT: decode = CIM_IDX_CHAN_OUT;
        CIM_OFF_CHAN_IN: decode = CIM_IDX_CHAN_IN;
        CIM_OFF_CTRL_STATE: decode = CIM_IDX_CTRL_STATE;
        CIM_OFF_XFER_WORD: decode = CIM_IDX_XFER_WORD;
        CIM_OFF_EXTRA_ONE: decode = CIM_IDX_EXTRA_ONE;
        CIM_OFF_CONTROL: decode = CIM_IDX_CONTROL;
        default: decode = CIM_IDX_NONE;
      endcase
    end
  endfunction : decode

  cim_state_t s_q;
  cim_state_t s_d;

  logic take;
  logic wr_go;
  logic in_data_phase;
  logic stop_or;
  logic unit_match;
  logic dev_match;
  logic [15:0] in_view;
  logic [15:0] out_view;
  logic [15:0] cs_view;
  logic [15:0] extra_view;
  logic [15:0] ctl_view;
  logic [15:0] sel_word;

  // ************************************************************
  // Combinational views
  // ************************************************************
  always_comb begin
    take = hsel && htrans[1] && hready;
    in_data_phase = (s_q.bus == CIM_BUS_WRITE);
    wr_go = in_data_phase && (s_q.ap_idx != CIM_IDX_NONE);
    stop_or = (|stop_conditions) && ((s_q.cs_reg[14:12] == CIM_PHASE_DATA_A) ||
              (s_q.cs_reg[14:12] == CIM_PHASE_DATA_B));
    unit_match = ((bus_out_lines[7:0] ^ unit_address) & CIM_UNIT_ADDR_MASK) == 8'h00;
    dev_match = unit_match && (bus_out_lines[7:0] == unit_address);
    // Live line view on-line, buffered copy off-line or cabled
    if (s_q.cs_reg[CIM_CS_ONLINE] && !s_q.cabled_test) begin
      out_view = bus_out_lines;
    end else begin
      out_view = s_q.out_buf;
    end
    if (s_q.cs_reg[CIM_CS_ONLINE]) begin
      in_view = test_in_plug;
    end else begin
      in_view = s_q.in_reg;
      in_view[CIM_IN_PARITY] = odd_par(s_q.in_reg[7:0]);
    end
    in_view[CIM_IN_CLOCK_OUT] = clock_out_line;
    cs_view = s_q.cs_reg;
    cs_view[CIM_CS_STOP_OR] = stop_or;
    cs_view[CIM_CS_UNIT_MATCH] = unit_match;
    cs_view[CIM_CS_DEV_MATCH] = dev_match;
    extra_view = {s_q.tumble_idx, 1'b0, misc_signals};
    ctl_view = CIM_RST_WORD;
    ctl_view[CIM_CTL_ONLINE_REQ] = s_q.online_request;
    ctl_view[CIM_CTL_CABLED] = s_q.cabled_test;
    unique case (s_q.ap_idx)
      CIM_IDX_CHAN_OUT: sel_word = out_view;
      CIM_IDX_CHAN_IN: sel_word = in_view;
      CIM_IDX_CTRL_STATE: sel_word = cs_view;
      CIM_IDX_XFER_WORD: sel_word = s_q.xfer_word;
      CIM_IDX_EXTRA_ONE: sel_word = extra_view;
      CIM_IDX_CONTROL: sel_word = ctl_view;
      default: sel_word = CIM_RST_WORD;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    // Bus sequencing
    unique case (s_q.bus)
      CIM_BUS_IDLE, CIM_BUS_WRITE, CIM_BUS_RD_DONE: begin
        if (take) begin
          s_d.ap_idx = decode(haddr);
          s_d.bus = hwrite ? CIM_BUS_WRITE : CIM_BUS_RD_WAIT;
        end else begin
          s_d.bus = CIM_BUS_IDLE;
        end
      end
      CIM_BUS_RD_WAIT: begin
        // Wait state lets a preceding write settle before sampling
        s_d.rdata = {16'h0000, sel_word};
        s_d.bus = CIM_BUS_RD_DONE;
      end
    endcase

    // Control-state capture from the core
    s_d.cs_reg[CIM_CS_LOCKOUT] = lockout_flag;
    s_d.cs_reg[14:12] = core_phase;
    s_d.cs_reg[CIM_CS_TIME_STATE] = time_state_flag;
    s_d.cs_reg[CIM_CS_FAST_BUSY] = fast_busy_diag;
    s_d.cs_reg[CIM_CS_SYNC] = core_sync;
    s_d.cs_reg[CIM_CS_UNIT_DATA] = unit_data_ctrl;
    s_d.cs_reg[CIM_CS_STOP_OR] = 1'b0;
    s_d.cs_reg[CIM_CS_BYPASS] = bypass_flag;
    s_d.cs_reg[CIM_CS_XFER_REQ] = transfer_request_flag;
    s_d.cs_reg[CIM_CS_XFER_DIR] = transfer_direction;
    s_d.cs_reg[CIM_CS_BYTE_ALT] = byte_alternator;
    s_d.cs_reg[CIM_CS_UNIT_MATCH] = 1'b0;
    s_d.cs_reg[CIM_CS_DEV_MATCH] = 1'b0;
    if (online_switch_en && !channel_active) begin
      s_d.cs_reg[CIM_CS_ONLINE] = s_q.online_request;
    end

    // Inbound register: core load, then maintenance write
    if (core_in_load) begin
      s_d.in_reg = core_in_value & CIM_IN_WRITE_MASK;
    end
    if (wr_go && (s_q.ap_idx == CIM_IDX_CHAN_IN)) begin
      s_d.in_reg = hwdata[15:0] & CIM_IN_WRITE_MASK;
    end

    // Outbound writes land in the buffer only
    if (wr_go && (s_q.ap_idx == CIM_IDX_CHAN_OUT) &&
        (!s_q.cs_reg[CIM_CS_ONLINE] || s_q.cabled_test)) begin
      s_d.out_buf = hwdata[15:0];
    end

    // Memory transfer word capture
    if (xfer_word_valid) begin
      s_d.xfer_word = xfer_word_in;
    end

    // Tumble index: software load has priority over advance
    if (tumble_advance) begin
      s_d.tumble_idx = s_q.tumble_idx + 8'h01;
    end
    if (wr_go && (s_q.ap_idx == CIM_IDX_EXTRA_ONE)) begin
      s_d.tumble_idx = hwdata[15:8];
    end

    // Setup control, frozen under lockout
    if (wr_go && (s_q.ap_idx == CIM_IDX_CONTROL) && !s_q.cs_reg[CIM_CS_LOCKOUT]) begin
      s_d.online_request = hwdata[CIM_CTL_ONLINE_REQ];
      s_d.cabled_test = hwdata[CIM_CTL_CABLED];
    end

    // Bus initialize
    if (bus_init) begin
      s_d.cs_reg = s_d.cs_reg & 16'h0004;
      s_d.in_reg = s_d.in_reg & CIM_IN_KEEP_MASK;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.bus <= CIM_BUS_IDLE;
      s_q.ap_idx <= CIM_IDX_NONE;
      s_q.rdata <= CIM_RST_RDATA;
      s_q.out_buf <= CIM_RST_WORD;
      s_q.in_reg <= CIM_RST_WORD;
      s_q.cs_reg <= CIM_RST_WORD;
      s_q.xfer_word <= CIM_RST_WORD;
      s_q.tumble_idx <= CIM_RST_BYTE;
      s_q.online_request <= 1'b0;
      s_q.cabled_test <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    hreadyout = (s_q.bus != CIM_BUS_RD_WAIT);
    hresp = 1'b0;
    hrdata = s_q.rdata;
    test_out_lines = s_q.out_buf;
    sim_clock_out = s_q.cabled_test && s_q.out_buf[CIM_OUT_PARITY_BIT];
    parity_out_line = s_q.out_buf[CIM_OUT_PARITY_BIT];
    out_parity_good = ^bus_out_lines[8:0];
    bus_in_o = s_q.in_reg;
    bus_in_o[CIM_IN_CLOCK_OUT] = 1'b0;
    bus_in_o[CIM_IN_PARITY] = odd_par(s_q.in_reg[7:0]);
    bus_in_oe = s_q.in_reg[CIM_IN_OPERATIONAL] || fast_busy_diag;
    online_actual = s_q.cs_reg[CIM_CS_ONLINE];
    online_request = s_q.online_request;
    cabled_test = s_q.cabled_test;
    regs_locked = s_q.cs_reg[CIM_CS_LOCKOUT];
    tumble_addr_low = {s_q.tumble_idx, 1'b0};
  end

endmodule : cim_regs

// >>> testbench/cim_regs_props.sv
module cim_regs_props (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic bus_init, // Initialize
  input wire logic [15:0] bus_out_lines, // Bus-out
  input wire logic online_switch_en, // Switch
  input wire logic channel_active, // Activity
  input wire logic lockout_flag, // Lockout in
  input wire logic fast_busy_diag, // Fast busy
  input wire logic tumble_advance, // Index step
  input wire logic sim_clock_out, // Sim clock
  input wire logic parity_out_line, // Parity line
  input wire logic out_parity_good, // Parity check
  input wire logic [15:0] bus_in_o, // Bus-in
  input wire logic bus_in_oe, // Bus-in enable
  input wire logic online_actual, // Connected
  input wire logic online_request, // Requested
  input wire logic cabled_test, // Cabled
  input wire logic regs_locked, // Locked
  input wire logic [8:0] tumble_addr_low // Index shifted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_q;

  // ****************************************
  // Write to extra-signals register in data phase
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= hsel & htrans[1] & hready & hwrite & (haddr == 32'h00000010);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_sim_clock: assert property (sim_clock_out == (cabled_test & parity_out_line))
    else $error("sim clock wrong");
  chk_out_parity: assert property (out_parity_good == ^bus_out_lines[8:0])
    else $error("out parity check wrong");
  chk_in_parity: assert property (bus_in_o[8] == ~^bus_in_o[7:0])
    else $error("in parity wrong");
  chk_in_drive: assert property (bus_in_oe == (bus_in_o[15] | fast_busy_diag))
    else $error("bus-in enable wrong");
  chk_lock_follow: assert property (!bus_init |=> regs_locked == $past(lockout_flag))
    else $error("lockout not followed");
  chk_init_clear: assert property (bus_init |=> !regs_locked)
    else $error("init did not clear");
  chk_online_hold: assert property (!online_switch_en || channel_active |=> $stable(online_actual))
    else $error("online moved");
  chk_online_next: assert property (online_switch_en && !channel_active |=>
    online_actual == $past(online_request)) else $error("online not second stage");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait wrong");
  chk_write_fast: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write waited");
  chk_tumble_step: assert property (tumble_advance && !ext_q |=>
    tumble_addr_low == $past(tumble_addr_low) + 9'h002) else $error("tumble step wrong");
endmodule : cim_regs_props

bind cim_regs cim_regs_props chk_u (.*);

// >>> testbench/cim_chan_model.sv
module cim_chan_model (
  input wire logic [7:0] out_byte, // Data byte
  input wire logic [6:0] out_tags, // Tag lines
  input wire logic bad_par, // Send even parity
  input wire logic clk_lvl, // Clock-out level
  output logic [15:0] bus_out_lines, // Bus-out
  output logic clock_out_line // Cable clock-out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    bus_out_lines = {out_tags, ~^out_byte ^ bad_par, out_byte};
    clock_out_line = clk_lvl;
  end
endmodule : cim_chan_model

// >>> testbench/cim_regs_tb.sv
module cim_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cim_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bus_init, online_switch_en;
  logic channel_active, core_in_load, xfer_word_valid, tumble_advance, clock_out_line;
  logic lockout_flag, time_state_flag, fast_busy_diag, core_sync, unit_data_ctrl, bypass_flag;
  logic transfer_request_flag, transfer_direction, byte_alternator, sim_clock_out;
  logic parity_out_line, out_parity_good, bus_in_oe, online_actual, online_request;
  logic cabled_test, regs_locked, bad_par, clk_lvl;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] seed = 32'h1B37;
  logic [15:0] bus_out_lines, test_in_plug, core_in_value, xfer_word_in, test_out_lines;
  logic [15:0] bus_in_o, core;
  logic [15:0] mdl [8];
  logic [7:0] unit_address, out_byte;
  logic [6:0] misc_signals, out_tags;
  logic [3:0] stop_conditions;
  logic [2:0] core_phase;
  logic [1:0] htrans;
  logic [8:0] tumble_addr_low;
  int mismatches, checks_done, i;

  assign {lockout_flag, core_phase, time_state_flag, fast_busy_diag, core_sync, unit_data_ctrl,
    bypass_flag, transfer_request_flag, transfer_direction, byte_alternator, stop_conditions} = core;
  cim_regs dut_u (.*, .hsize(3'h2), .hready(hreadyout));
  cim_chan_model chan_u (.*);
  always #20 hclk = ~hclk;

  // ****************************************
  // Tasks and expectations
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] cs_exp();
    logic stp;
    stp = (core_phase == 3'h5 || core_phase == 3'h6) & |stop_conditions;
    return {lockout_flag, core_phase, time_state_flag, fast_busy_diag, core_sync, unit_data_ctrl,
      stp, bypass_flag, transfer_request_flag, transfer_direction, byte_alternator, mdl[7][0],
      out_byte[7:4] == unit_address[7:4], out_byte == unit_address};
  endfunction : cs_exp

  function automatic logic [15:0] in_exp();
    if (mdl[7][0]) return {test_in_plug[15:10], clk_lvl, test_in_plug[8:0]};
    return {mdl[1][15:10], clk_lvl, ~^mdl[1][7:0], mdl[1][7:0]};
  endfunction : in_exp

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(negedge hclk); while (!hreadyout && ++n < 99);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(negedge hclk); while (!hreadyout && ++n < 99);
    r = hrdata[15:0];
    @(negedge hclk);
    if (n >= 99) mismatches++;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    xfer(1'b1, a, d, r);
    if (a == 8'h00 && !(mdl[7][0] && !mdl[5][0])) mdl[0] = d;
    if (a == 8'h04) mdl[1] = d & 16'hFCFF;
    if (a == 8'h10) mdl[4] = {d[15:8], 8'h00};
    if (a == 8'h14 && !lockout_flag) mdl[5] = d & 16'h0201;
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] r;
    xfer(1'b0, a, 16'h0000, r);
    chk(nm, e, r);
  endtask : rc

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0; core = 0;
    {bus_init, online_switch_en, channel_active, core_in_load, xfer_word_valid} = '0;
    {tumble_advance, bad_par, clk_lvl, test_in_plug, core_in_value, xfer_word_in} = '0;
    {unit_address, out_byte, misc_signals, out_tags} = '0;
    mdl = '{default: 16'h0000};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rc("reset state", 8'h08, cs_exp());
    rc("unmapped", 8'h1C, 16'h0000);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      if (i == 2) wr(8'h14, 16'h0001);
      wr(8'h00, {seed[15:9], i[0], seed[7:0]});
      chk("test out", mdl[0], test_out_lines);
      chk("sim clock", {15'h0, mdl[5][0] & mdl[0][8]}, {15'h0, sim_clock_out});
      chk("parity line", {15'h0, mdl[0][8]}, {15'h0, parity_out_line});
      rc("outbound", 8'h00, mdl[0]);
      @(posedge hclk);
      {out_tags, out_byte} <= seed[30:16];
      bad_par <= i[0];
      clk_lvl <= seed[20];
      @(negedge hclk);
      chk("parity good", {15'h0, !i[0]}, {15'h0, out_parity_good});
      wr(8'h04, seed[15:0]);
      chk("bus in", {mdl[1][15:10], 1'b0, ~^mdl[1][7:0], mdl[1][7:0]}, bus_in_o);
      rc("inbound", 8'h04, in_exp());
    end
    wr(8'h14, 16'h0000);
    @(posedge hclk);
    core_in_load <= 1'b1;
    core_in_value <= seed[31:16] | 16'h4300;
    @(posedge hclk);
    core_in_load <= 1'b0;
    mdl[1] = (seed[31:16] | 16'h4300) & 16'hFCFF;
    rc("core load", 8'h04, in_exp());
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge hclk);
      core <= {seed[15], i[2:0], seed[11:0]};
      unit_address <= {i[1] ? out_byte[7:4] : seed[23:20], out_byte[3:0] ^ {3'h0, i[0]}};
      @(negedge hclk);
      rc("ctrl state", 8'h08, cs_exp());
      chk("okay resp", 16'h0000, {15'h0, hresp});
      wr(8'h08, ~seed[15:0]);
    end
    @(posedge hclk);
    core <= 16'h8000;
    wr(8'h14, 16'h0200);
    chk("locked", 16'h0000, {15'h0, online_request});
    @(posedge hclk);
    core <= 16'h0000;
    online_switch_en <= 1'b1;
    wr(8'h14, 16'h0200);
    mdl[7] = 16'h0001;
    rc("online", 8'h08, cs_exp());
    @(posedge hclk);
    test_in_plug <= seed[31:16];
    @(negedge hclk);
    rc("plug", 8'h04, in_exp());
    channel_active <= 1'b1;
    wr(8'h14, 16'h0000);
    wr(8'h00, ~seed[15:0]);
    rc("live out", 8'h00, bus_out_lines);
    @(posedge hclk);
    core <= 16'h8000;
    bus_init <= 1'b1;
    @(posedge hclk);
    bus_init <= 1'b0;
    core <= 16'h0000;
    @(negedge hclk);
    rc("init keep", 8'h08, cs_exp());
    @(posedge hclk);
    channel_active <= 1'b0;
    mdl[7] = 16'h0000;
    mdl[1] = mdl[1] & 16'h4000;
    rc("init in", 8'h04, in_exp());
    @(posedge hclk);
    xfer_word_valid <= 1'b1;
    xfer_word_in <= seed[15:0];
    @(posedge hclk);
    xfer_word_valid <= 1'b0;
    wr(8'h0C, ~seed[15:0]);
    rc("xfer word", 8'h0C, seed[15:0]);
    wr(8'h10, seed[31:16] | 16'h0080);
    @(posedge hclk);
    tumble_advance <= 1'b1;
    misc_signals <= seed[6:0];
    repeat (2) @(posedge hclk);
    tumble_advance <= 1'b0;
    mdl[4][15:8] = mdl[4][15:8] + 8'h02;
    rc("extra", 8'h10, {mdl[4][15:8], 1'b0, seed[6:0]});
    chk("tumble addr", {7'h00, mdl[4][15:8], 1'b0}, {7'h00, tumble_addr_low});
    print_verdict();
  end
endmodule : cim_regs_tb
